// *** common/ass_pkg.sv ***
/*
 scan sequencer package: register offsets, field positions, reset values,
 state timing counts and carrier structs.
 assumes one 200 MHz clock; one state equals one clock cycle.
*/
package ass_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int RES_W = 10;
   localparam int CH_W = 3;
   localparam int NUM_CH = 8;
   // register offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_TRIG = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_RES0 = 4'h8;
   // control/status and trigger field positions
   localparam int BIT_END = 7;
   localparam int BIT_IE = 6;
   localparam int BIT_START = 5;
   localparam int BIT_SCAN = 4;
   localparam int BIT_SPEED = 3;
   localparam int BIT_GROUP = 2;
   localparam int BIT_TIMER_TRIGGER_ENABLE = 7;
   localparam logic [DATA_W-1:0] TRIG_RESERVED = 16'h007F;
   localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
   // timing, in states
   localparam int DELAY_SLOW_MIN = 10;
   localparam int DELAY_SLOW_MAX = 17;
   localparam int DELAY_FAST_MIN = 6;
   localparam int DELAY_FAST_MAX = 9;
   localparam int SAMPLE_SLOW = 64;
   localparam int SAMPLE_FAST = 32;
   localparam int CONV_SLOW = 256;
   localparam int CONV_FAST = 128;
   // first conversion total, from the start write to the done pulse
   localparam int CONV_FIRST_SLOW_MIN = 259;
   localparam int CONV_FIRST_SLOW_MAX = 266;
   localparam int CONV_FIRST_FAST_MIN = 131;
   localparam int CONV_FIRST_FAST_MAX = 134;
   localparam int CNT_W = 9;
   // phase of the internal timing grid, one length per speed, equal to the number of delay values in that speed's range
   localparam int PHASE_SLOW = DELAY_SLOW_MAX - DELAY_SLOW_MIN + 1;
   localparam int PHASE_FAST = DELAY_FAST_MAX - DELAY_FAST_MIN + 1;
   localparam int PH_W = 3;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } ass_bus_req_t;

   typedef enum logic [1:0] {ASS_IDLE, ASS_DELAY, ASS_SAMPLE, ASS_CONVERT} ass_state_t;
endpackage : ass_pkg

// *** hw/ass_scan_sequencer.sv ***
/*
 scan-mode conversion sequencer with result registers and trigger start.
 assumes a sample/hold and bit-decision analog core outside: it samples on
 sampleHold, and holds analogCode steady until convDone is pulsed by this block.
 the timer trigger and analogCode come from other domains and are synchronised.
*/
`timescale 1ns/10ps
module ass_scan_sequencer
   import ass_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire ass_pkg::ass_bus_req_t busReq,
   output logic [ass_pkg::DATA_W-1:0] busRdata,
   input wire logic timerTrigger,
   input wire logic [ass_pkg::RES_W-1:0] analogCode,
   output logic [ass_pkg::CH_W-1:0] activeChannel,
   output logic sampleHold,
   output logic convDone,
   output logic endInterrupt
);
   import ass_pkg::*;

   function automatic logic [CNT_W-1:0] phaseLen(input ass_state_t st, input logic fast, input logic first);
      logic [CNT_W-1:0] n;
      n = '0;
      unique case (st)
         ASS_SAMPLE: n = fast ? CNT_W'(SAMPLE_FAST) : CNT_W'(SAMPLE_SLOW);
         ASS_CONVERT: begin
            // first conversion absorbs the minimum start delay, so its total stays in range
            if (first) n = fast ? CNT_W'(CONV_FIRST_FAST_MIN - DELAY_FAST_MIN - SAMPLE_FAST)
                                : CNT_W'(CONV_FIRST_SLOW_MIN - DELAY_SLOW_MIN - SAMPLE_SLOW);
            else n = fast ? CNT_W'(CONV_FAST - SAMPLE_FAST) : CNT_W'(CONV_SLOW - SAMPLE_SLOW);
         end
         ASS_DELAY: n = '0;
         ASS_IDLE: n = '0;
      endcase
      return n;
   endfunction : phaseLen

   // synchronisers
   logic [1:0] trigSync_reg;
   logic trigPrev_reg;
   logic [RES_W-1:0] codeMeta_reg, codeSync_reg;

   // control state
   logic endFlag_reg, endFlag_next;
   logic endSeen_reg, endSeen_next;
   logic intEn_reg, intEn_next;
   logic start_reg, start_next;
   logic scan_reg, scan_next;
   logic fast_reg, fast_next;
   logic [CH_W-1:0] chSel_reg, chSel_next;
   logic timer_trigger_enable_reg, timer_trigger_enable_next;
   logic [RES_W-1:0] result_reg [NUM_CH];
   logic [RES_W-1:0] result_next [NUM_CH];
   logic [DATA_W-1:0] rdata_reg, rdata_next;

   // sequencer state
   ass_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [PH_W-1:0] phase_reg, phase_next;
   logic [CH_W-1:0] chan_reg, chan_next;
   logic firstConv_reg, firstConv_next;
   logic sample_reg, sample_next;
   logic done_reg, done_next;
   logic irq_reg, irq_next;

   logic trigEdge;
   logic [CH_W-1:0] firstCh, lastCh;
   assign trigEdge = trigSync_reg[1] & ~trigPrev_reg;
   assign firstCh = chSel_reg[BIT_GROUP] ? CH_W'(4) : CH_W'(0);
   assign lastCh = scan_reg ? (firstCh | {1'b0, chSel_reg[1:0]}) : chSel_reg;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         trigSync_reg <= '0;
         trigPrev_reg <= 1'b0;
         codeMeta_reg <= '0;
         codeSync_reg <= '0;
      end else begin
         trigSync_reg <= {trigSync_reg[0], timerTrigger};
         trigPrev_reg <= trigSync_reg[1];
         codeMeta_reg <= analogCode;
         codeSync_reg <= codeMeta_reg;
      end
   end

   // register file and sequencer next values
   always_comb begin
      logic stopNow, trigStart, swStart, startRise, doneNow;
      stopNow = 1'b0;
      trigStart = 1'b0;
      swStart = 1'b0;
      startRise = 1'b0;
      doneNow = 1'b0;
      endFlag_next = endFlag_reg;
      endSeen_next = endSeen_reg;
      intEn_next = intEn_reg;
      start_next = start_reg;
      scan_next = scan_reg;
      fast_next = fast_reg;
      chSel_next = chSel_reg;
      timer_trigger_enable_next = timer_trigger_enable_reg;
      result_next = result_reg;
      rdata_next = '0;
      state_next = state_reg;
      cnt_next = cnt_reg;
      phase_next = fast_reg ? ((phase_reg >= PH_W'(PHASE_FAST - 1)) ? '0 : phase_reg + PH_W'(1))
                            : ((phase_reg >= PH_W'(PHASE_SLOW - 1)) ? '0 : phase_reg + PH_W'(1));
      chan_next = chan_reg;
      firstConv_next = firstConv_reg;
      sample_next = 1'b0;
      done_next = 1'b0;

      if (busReq.rd) begin
         if (busReq.addr == OFF_CTRL) begin
            rdata_next = {8'h00, endFlag_reg, intEn_reg, start_reg, scan_reg, fast_reg, chSel_reg};
            if (endFlag_reg) endSeen_next = 1'b1;
         end else if (busReq.addr == OFF_TRIG) begin
            rdata_next = TRIG_RESERVED | (DATA_W'(timer_trigger_enable_reg) << BIT_TIMER_TRIGGER_ENABLE);
         end else if (busReq.addr >= OFF_RES0) begin
            rdata_next = DATA_W'(result_reg[busReq.addr[CH_W-1:0]]);
         end
      end
      if (busReq.wr && busReq.addr == OFF_CTRL) begin
         intEn_next = busReq.wdata[BIT_IE];
         scan_next = busReq.wdata[BIT_SCAN];
         fast_next = busReq.wdata[BIT_SPEED];
         chSel_next = busReq.wdata[CH_W-1:0];
         start_next = busReq.wdata[BIT_START];
         swStart = busReq.wdata[BIT_START] & ~start_reg;
         stopNow = ~busReq.wdata[BIT_START];
         if (!busReq.wdata[BIT_END] && endSeen_reg) begin
            endFlag_next = 1'b0;
            endSeen_next = 1'b0;
         end
      end
      if (busReq.wr && busReq.addr == OFF_TRIG) timer_trigger_enable_next = busReq.wdata[BIT_TIMER_TRIGGER_ENABLE];
      trigStart = trigEdge & timer_trigger_enable_reg & ~start_next;
      if (trigStart) start_next = 1'b1;
      startRise = swStart | trigStart;

      unique case (state_reg)
         ASS_IDLE: ;
         ASS_DELAY: begin
            // delay tail aligned to the internal grid gives the documented spread
            if (cnt_reg != '0) cnt_next = cnt_reg - CNT_W'(1);
            else if (phase_reg == '0) begin
               state_next = ASS_SAMPLE;
               cnt_next = phaseLen(ASS_SAMPLE, fast_reg, firstConv_reg) - CNT_W'(1);
               sample_next = 1'b1;
            end
         end
         ASS_SAMPLE: begin
            sample_next = (cnt_reg != '0);
            if (cnt_reg != '0) cnt_next = cnt_reg - CNT_W'(1);
            else begin
               state_next = ASS_CONVERT;
               cnt_next = phaseLen(ASS_CONVERT, fast_reg, firstConv_reg) - CNT_W'(1);
            end
         end
         ASS_CONVERT: begin
            if (cnt_reg != '0) cnt_next = cnt_reg - CNT_W'(1);
            else doneNow = 1'b1;
         end
      endcase

      if (doneNow) begin
         done_next = 1'b1;
         result_next[chan_reg] = codeSync_reg;
         firstConv_next = 1'b0;
         if (!scan_reg) begin
            state_next = ASS_IDLE;
            start_next = 1'b0;
            endFlag_next = 1'b1;
         end else begin
            if (chan_reg == lastCh) begin
               endFlag_next = 1'b1;
               chan_next = firstCh;
            end else begin
               chan_next = chan_reg + CH_W'(1);
            end
            // back-to-back scans skip the delay: 256/128 states each
            state_next = ASS_SAMPLE;
            cnt_next = phaseLen(ASS_SAMPLE, fast_reg, 1'b0) - CNT_W'(1);
            sample_next = 1'b1;
         end
      end
      if (startRise) begin
         state_next = ASS_DELAY;
         chan_next = scan_next ? (chSel_next[BIT_GROUP] ? CH_W'(4) : CH_W'(0)) : chSel_next;
         firstConv_next = 1'b1;
         cnt_next = fast_next ? CNT_W'(DELAY_FAST_MIN - 1) : CNT_W'(DELAY_SLOW_MIN - 1);
         sample_next = 1'b0;
      end else if (stopNow && busReq.wr) begin
         state_next = ASS_IDLE;
         sample_next = 1'b0;
      end
      irq_next = endFlag_next & intEn_next;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         endFlag_reg <= 1'b0;
         endSeen_reg <= 1'b0;
         intEn_reg <= 1'b0;
         start_reg <= 1'b0;
         scan_reg <= 1'b0;
         fast_reg <= 1'b0;
         chSel_reg <= '0;
         timer_trigger_enable_reg <= 1'b0;
         result_reg <= '{default: '0};
         rdata_reg <= '0;
         state_reg <= ASS_IDLE;
         cnt_reg <= '0;
         phase_reg <= '0;
         chan_reg <= '0;
         firstConv_reg <= 1'b0;
         sample_reg <= 1'b0;
         done_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         endFlag_reg <= endFlag_next;
         endSeen_reg <= endSeen_next;
         intEn_reg <= intEn_next;
         start_reg <= start_next;
         scan_reg <= scan_next;
         fast_reg <= fast_next;
         chSel_reg <= chSel_next;
         timer_trigger_enable_reg <= timer_trigger_enable_next;
         result_reg <= result_next;
         rdata_reg <= rdata_next;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         phase_reg <= phase_next;
         chan_reg <= chan_next;
         firstConv_reg <= firstConv_next;
         sample_reg <= sample_next;
         done_reg <= done_next;
         irq_reg <= irq_next;
      end
   end

   assign busRdata = rdata_reg;
   assign activeChannel = chan_reg;
   assign sampleHold = sample_reg;
   assign convDone = done_reg;
   assign endInterrupt = irq_reg;

   // assertion helper: cycles since conversion start; a done opens the next scan conversion at one
   logic [CNT_W-1:0] convAge_reg;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) convAge_reg <= '0;
      else if (state_reg == ASS_IDLE) convAge_reg <= '0;
      else if (done_reg) convAge_reg <= CNT_W'(1);
      else convAge_reg <= convAge_reg + CNT_W'(1);
   end

   // assertion helper: cycles the hold has stood open
   logic [CNT_W-1:0] sampleAge_reg;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) sampleAge_reg <= '0;
      else if (sample_reg) sampleAge_reg <= sampleAge_reg + CNT_W'(1);
      else sampleAge_reg <= '0;
   end

   a_irq_follows_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (endFlag_reg && intEn_reg) |-> endInterrupt) else $error("interrupt missing");
   a_scan_wraps_first: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (done_reg && scan_reg && start_reg && $past(chan_reg) == lastCh && $past(state_reg) == ASS_CONVERT)
      |-> (chan_reg == firstCh && endFlag_reg)) else $error("scan did not wrap");
   a_scan_next_channel: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (done_reg && scan_reg && $past(chan_reg) != lastCh && $past(state_reg) == ASS_CONVERT && !$past(busReq.wr))
      |-> chan_reg == $past(chan_reg) + CH_W'(1)) else $error("channel not advanced");
   a_scan_exact_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (done_reg && scan_reg && !fast_reg && !$past(firstConv_reg)) |-> $past(convAge_reg) == CNT_W'(CONV_SLOW - 1))
      else $error("scan conversion length wrong");
   a_first_conv_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (done_reg && $past(firstConv_reg) && !fast_reg) |->
      ($past(convAge_reg) >= CNT_W'(CONV_FIRST_SLOW_MIN - 1) && $past(convAge_reg) <= CNT_W'(CONV_FIRST_SLOW_MAX - 1)))
      else $error("first conversion out of range");
   a_sample_length: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ($fell(sampleHold) && state_reg == ASS_CONVERT) |->
      sampleAge_reg == (fast_reg ? CNT_W'(SAMPLE_FAST) : CNT_W'(SAMPLE_SLOW))) else $error("sampling length wrong");
   a_trigger_gated: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (trigEdge && !timer_trigger_enable_reg && !busReq.wr && !start_reg) |=> !start_reg) else $error("trigger not gated");
   a_stop_idles: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (busReq.wr && busReq.addr == OFF_CTRL && !busReq.wdata[BIT_START]) |=> state_reg == ASS_IDLE)
      else $error("stop ignored");
endmodule : ass_scan_sequencer

// *** testbench/ass_analog_model.sv ***
/*
 far-side model: analog core codes per channel and a timer trigger source.
 assumes the sequencer samples on sampleHold and captures analogCode at convDone.
*/
`timescale 1ns/10ps
module ass_analog_model
   import ass_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [ass_pkg::CH_W-1:0] activeChannel,
   input wire logic sampleHold,
   input wire logic convDone,
   input wire logic fireTrigger,
   output logic [ass_pkg::RES_W-1:0] analogCode,
   output logic timerTrigger
);
   logic [RES_W-1:0] curCode;
   logic busy;
   logic shPrev;
   logic [2:0] relCnt;
   logic [2:0] trigCnt;

   function automatic logic [RES_W-1:0] codeFor(input logic [CH_W-1:0] ch);
      case (ch)
         3'h0: codeFor = 10'h3FF;
         3'h2: codeFor = 10'h000;
         default: codeFor = {ch, 7'h35};
      endcase
   endfunction : codeFor

   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         analogCode <= 10'h155;
         curCode <= 10'h155;
         busy <= 1'b0;
         shPrev <= 1'b0;
         relCnt <= 3'h0;
         trigCnt <= 3'h0;
         timerTrigger <= 1'b0;
      end else begin
         shPrev <= sampleHold;
         if (convDone) begin
            busy <= 1'b0;
            relCnt <= 3'h4;
         end else if (relCnt != 3'h0) begin
            relCnt <= relCnt - 3'h1;
         end
         // in scan the next sample opens with convDone: it must leave the core busy
         if (sampleHold && !shPrev) begin
            curCode <= codeFor(activeChannel);
            analogCode <= codeFor(activeChannel);
            busy <= 1'b1;
         end else if (relCnt == 3'h1 && !busy) begin
            // held value lapses once the core is done with it
            analogCode <= ~curCode;
         end
         // trigger held a few cycles so it survives the synchroniser
         if (fireTrigger) begin
            trigCnt <= 3'h4;
         end else if (trigCnt != 3'h0) begin
            trigCnt <= trigCnt - 3'h1;
         end
         timerTrigger <= fireTrigger || (trigCnt > 3'h1);
      end
   end
endmodule : ass_analog_model

// *** testbench/ass_scan_sequencer_bench.sv ***
/*
 self-checking bench for the scan sequencer: register tasks, scan scenarios, trigger start.
 assumes the analog model codes and a 200 MHz clock.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin nCompared++; if ((got) !== (ex)) begin failCount++; \
   $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module ass_scan_sequencer_bench;
   import ass_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic fireTrigger = 1'b0;
   logic shSeen = 1'b0;
   ass_bus_req_t busReq = '0;
   logic [DATA_W-1:0] busRdata;
   logic [DATA_W-1:0] rd;
   logic timerTrigger, sampleHold, convDone, endInterrupt;
   logic [RES_W-1:0] analogCode;
   logic [CH_W-1:0] activeChannel;
   logic [CH_W-1:0] chans[$];
   int dones[$], starts[$];
   int failCount = 0, nCompared = 0, cyc = 0, lastWr = 0, expSample = 0;

   always #2.5 sys_clk = ~sys_clk;

   ass_scan_sequencer uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .busReq(busReq), .busRdata(busRdata),
      .timerTrigger(timerTrigger), .analogCode(analogCode), .activeChannel(activeChannel),
      .sampleHold(sampleHold), .convDone(convDone), .endInterrupt(endInterrupt));
   ass_analog_model core (.sys_clk(sys_clk), .sys_rst(sys_rst), .activeChannel(activeChannel),
      .sampleHold(sampleHold), .convDone(convDone), .fireTrigger(fireTrigger),
      .analogCode(analogCode), .timerTrigger(timerTrigger));

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      shSeen <= sampleHold;
      if (sampleHold && !shSeen) begin
         chans.push_back(activeChannel);
         starts.push_back(cyc);
      end
      // width skipped while a stop may cut sampling short
      if (!sampleHold && shSeen && expSample != 0) `CHK("sampleWidth", expSample, cyc - starts[$])
      if (convDone) dones.push_back(cyc);
   end

   function automatic logic [DATA_W-1:0] expCode(input int c);
      case (c)
         0: expCode = 16'h03FF;
         2: expCode = 16'h0000;
         default: expCode = {6'h00, 3'(c), 7'h35};
      endcase
   endfunction : expCode

   task automatic busWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      busReq.addr <= a;
      busReq.wdata <= d;
      busReq.wr <= 1'b1;
      @(posedge sys_clk);
      busReq.wr <= 1'b0;
      #1 lastWr = cyc;
      @(posedge sys_clk);
   endtask : busWrite

   task automatic readChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
      busReq.addr <= a;
      busReq.rd <= 1'b1;
      @(posedge sys_clk);
      busReq.rd <= 1'b0;
      #1 rd = busRdata;
      `CHK(nm, e, rd)
      @(posedge sys_clk);
   endtask : readChk

   task automatic waitDones(input int n);
      int k;
      k = 0;
      while (dones.size() < n && k < 2000) begin
         @(posedge sys_clk);
         k++;
      end
      `CHK("doneCount", n, dones.size())
   endtask : waitDones

   task automatic checkScan(input logic [CH_W-1:0] base, input int nch, input int n, input int lo,
      input int hi, input int step, input int dlo, input int dhi);
      for (int i = 0; i < n; i++) begin
         `CHK("channel", base + CH_W'(i % nch), chans[i])
         if (i > 0) `CHK("convPeriod", step, dones[i] - dones[i-1])
      end
      `CHK("firstConv", 1'b1, (dones[0] - lastWr) inside {[lo:hi]})
      `CHK("startDelay", 1'b1, (starts[0] - lastWr) inside {[dlo:dhi]})
   endtask : checkScan

   task automatic clearLogs();
      dones.delete();
      chans.delete();
      starts.delete();
   endtask : clearLogs

   task automatic endSim();
      if (failCount == 0 && nCompared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : endSim

   initial begin
      #(10000 * 5);
      failCount++;
      $display("FAIL watchdog expected finish seen timeout");
      endSim();
   end

   initial begin
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      readChk(OFF_CTRL, CTRL_RESET, "ctrlReset");
      readChk(OFF_TRIG, TRIG_RESERVED, "trigReset");
      readChk(4'h5, 16'h0000, "unmapped");
      expSample = SAMPLE_FAST;
      busWrite(OFF_CTRL, 16'h007A);
      waitDones(1);
      readChk(OFF_CTRL, 16'h007A, "flagMidPass");
      waitDones(3);
      readChk(OFF_CTRL, 16'h00FA, "flagPassEnd");
      `CHK("interrupt", 1'b1, endInterrupt)
      waitDones(4);
      checkScan(3'h0, 3, 4, 131, 134, CONV_FAST, DELAY_FAST_MIN, DELAY_FAST_MAX);
      expSample = 0;
      busWrite(OFF_CTRL, 16'h005A);
      readChk(OFF_CTRL, 16'h005A, "stopClear");
      `CHK("interruptOff", 1'b0, endInterrupt)
      for (int c = 0; c < 3; c++) readChk(OFF_RES0 + ADDR_W'(c), expCode(c), "result");
      repeat (300) @(posedge sys_clk);
      `CHK("halted", 4, dones.size())
      clearLogs();
      expSample = SAMPLE_SLOW;
      busWrite(OFF_CTRL, 16'h0035);
      waitDones(3);
      checkScan(3'h4, 2, 3, 259, 266, CONV_SLOW, DELAY_SLOW_MIN, DELAY_SLOW_MAX);
      readChk(OFF_CTRL, 16'h00B5, "flagNoIe");
      `CHK("interruptMasked", 1'b0, endInterrupt)
      expSample = 0;
      busWrite(OFF_CTRL, 16'h0015);
      for (int c = 4; c < 6; c++) readChk(OFF_RES0 + ADDR_W'(c), expCode(c), "result");
      clearLogs();
      expSample = SAMPLE_SLOW;
      busWrite(OFF_CTRL, 16'h0065);
      waitDones(1);
      checkScan(3'h5, 1, 1, CONV_FIRST_SLOW_MIN, CONV_FIRST_SLOW_MAX, CONV_SLOW, DELAY_SLOW_MIN, DELAY_SLOW_MAX);
      readChk(OFF_CTRL, 16'h00C5, "singleEnd");
      `CHK("singleIrq", 1'b1, endInterrupt)
      repeat (300) @(posedge sys_clk);
      `CHK("singleHalt", 1, dones.size())
      busWrite(OFF_CTRL, 16'h0005);
      readChk(OFF_CTRL, 16'h0005, "singleClear");
      readChk(OFF_RES0 + ADDR_W'(5), expCode(5), "singleResult");
      clearLogs();
      busWrite(OFF_TRIG, 16'h0000);
      fireTrigger <= 1'b1;
      @(posedge sys_clk);
      fireTrigger <= 1'b0;
      repeat (40) @(posedge sys_clk);
      `CHK("trigDisabled", 0, chans.size())
      busWrite(OFF_TRIG, 16'h0080);
      readChk(OFF_TRIG, 16'h00FF, "trigEnable");
      busWrite(OFF_CTRL, 16'h001A);
      expSample = SAMPLE_FAST;
      fireTrigger <= 1'b1;
      @(posedge sys_clk);
      fireTrigger <= 1'b0;
      waitDones(1);
      readChk(OFF_CTRL, 16'h003A, "trigStart");
      `CHK("resumeFirst", 3'h0, chans[0])
      expSample = 0;
      busWrite(OFF_CTRL, 16'h001A);
      endSim();
   end
endmodule : ass_scan_sequencer_bench
